/* verilog/rsfm_pkg.sv */
// package for the relay system failure monitor: constants, types, register map
// assumes a 25 MHz system clock and an AXI4-Lite register bus with 32-bit data
package rsfm_pkg;
    // ==========================================================
    // geometry and timing
    localparam int NPTS          = 40;
    localparam int CLK_HZ        = 25_000_000;
    localparam int QUAL_MIN_S    = 5;
    localparam int QUAL_MAX_S    = 10;
    localparam int DET_STUCK_S   = 60;
    localparam longint QUAL_CYC_L = longint'(QUAL_MIN_S) * CLK_HZ;
    localparam longint STUCK_CYC_L = longint'(DET_STUCK_S) * CLK_HZ;
    localparam int CNT_W         = 32;
    localparam int BLINK_W       = 24;
    localparam logic [7:0] CODE_FD   = 8'hfd;
    localparam logic [7:0] CODE_NONE = 8'h00;

    // ==========================================================
    // register map, byte offsets
    localparam logic [7:0] REG_STATUS  = 8'h00;
    localparam logic [7:0] REG_MASK    = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_REC_LO  = 8'h0c;
    localparam logic [7:0] REG_REC_HI  = 8'h10;
    localparam logic [7:0] REG_STATE   = 8'h14;
    localparam int ADDR_W = 8;
    localparam int REC_HI_W = NPTS - 32;

    // status bits
    localparam int ST_PT_FAIL  = 0;
    localparam int ST_DET_FAIL = 1;
    localparam int ST_W        = 2;
    // control bits, write-one pulses
    localparam int CT_CLEAR    = 0;
    localparam int CT_STEP     = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [NPTS-1:0] rec;
        logic            alarm;
        logic            det_fail;
        logic            code_hidden;
    } rsfm_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } rsfm_wreq_t;
endpackage

/* verilog/rsfm_store.sv */
// holds the set of failed point identities, with read data from a register
// assumes non-volatility is provided by the technology cell; reset does not wipe it
`timescale 1ns/10ps
module rsfm_store
    import rsfm_pkg::*;
(
    // clock
    input  wire logic            clk,
    // update
    input  wire logic            set_en,
    input  wire logic [NPTS-1:0] set_bits,
    input  wire logic            clr,
    // read
    output logic      [NPTS-1:0] rd_data
);
    logic [NPTS-1:0] mem;

    // no reset: contents must survive supply loss and reset
    // a failure recorded in the same cycle as a clear is kept, so the set wins
    always_ff @(posedge clk) begin
        if (clr) begin
            mem <= set_en ? set_bits : '0;
        end else if (set_en) begin
            mem <= mem | set_bits;
        end
        rd_data <= mem;
    end
endmodule

/* verilog/rsfm_top.sv */
// relay system failure monitor: point change supervision, stuck detector alarm
// assumes points and buttons are asynchronous pins; software uses AXI4-Lite
`timescale 1ns/10ps
module rsfm_top
    import rsfm_pkg::*;
#(
    parameter longint QUAL_CYC  = QUAL_CYC_L,
    parameter longint STUCK_CYC = STUCK_CYC_L
) (
    // clock and reset
    input  wire logic            CLK,
    input  wire logic            RESET_N,
    // scheme inputs
    input  wire logic [NPTS-1:0] POINTS,
    input  wire logic            DISTURBANCE_DETECTOR,
    input  wire logic            CLEAR_BUTTON,
    input  wire logic            REMOTE_CLEAR,
    input  wire logic            STEP_VIEW_BUTTON,
    // indications
    output logic                 ALARM,
    output logic                 MONITOR_RECORD_LAMP,
    output logic [7:0]           DISPLAY_CODE,
    output logic                 IRQ,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic            S_AXI_AWVALID,
    output logic                 S_AXI_AWREADY,
    input  wire logic [31:0]     S_AXI_WDATA,
    input  wire logic [3:0]      S_AXI_WSTRB,
    input  wire logic            S_AXI_WVALID,
    output logic                 S_AXI_WREADY,
    output logic [1:0]           S_AXI_BRESP,
    output logic                 S_AXI_BVALID,
    input  wire logic            S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic            S_AXI_ARVALID,
    output logic                 S_AXI_ARREADY,
    output logic [31:0]          S_AXI_RDATA,
    output logic [1:0]           S_AXI_RRESP,
    output logic                 S_AXI_RVALID,
    input  wire logic            S_AXI_RREADY
);
    localparam int NIN = NPTS + 4;
    localparam logic [CNT_W-1:0] QUAL_N  = CNT_W'(QUAL_CYC - 1);
    localparam logic [CNT_W-1:0] STUCK_N = CNT_W'(STUCK_CYC - 1);

    // ==========================================================
    // input synchronisers
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NPTS-1:0] prev;
    logic            det_q;
    logic            btn_clr_q;
    logic            rem_clr_q;
    logic            step_q;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {STEP_VIEW_BUTTON, REMOTE_CLEAR, CLEAR_BUTTON,
                      DISTURBANCE_DETECTOR, POINTS};
            sync2 <= sync1;
        end
    end

    wire [NPTS-1:0] pts_s    = sync2[NPTS-1:0];
    wire            det_s    = sync2[NPTS];
    wire            clr_s    = sync2[NPTS+1];
    wire            rclr_s   = sync2[NPTS+2];
    wire            step_s   = sync2[NPTS+3];

    // ==========================================================
    // edge detection and pending change set
    logic            primed;
    logic [1:0]      warm;
    logic [NPTS-1:0] pend;
    logic [CNT_W-1:0] qual_cnt;
    logic [CNT_W-1:0] stuck_cnt;
    rsfm_state_t     st;
    logic            sw_clear;
    logic            sw_step;

    wire [NPTS-1:0] edges     = primed ? (pts_s ^ prev) : '0;
    wire            clear_cmd = (clr_s & ~btn_clr_q) | (rclr_s & ~rem_clr_q)
                                | sw_clear;
    wire            step_cmd  = (step_s & ~step_q) | sw_step;
    // a detector pickup means a disturbance; changes then are expected
    wire            quiet     = ~det_s;
    wire            qual_done = (|pend) && quiet && (qual_cnt == QUAL_N);
    wire            stuck_hit = det_s && (stuck_cnt == STUCK_N);
    wire            rec_en    = qual_done && !st.det_fail;
    wire            pt_event  = rec_en;
    wire            det_event = stuck_hit && !st.det_fail;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prev      <= '0;
            primed    <= 1'b0;
            warm      <= '0;
            det_q     <= 1'b0;
            btn_clr_q <= 1'b0;
            rem_clr_q <= 1'b0;
            step_q    <= 1'b0;
        end else begin
            prev      <= pts_s;
            // prev holds real pin levels only from the third edge; no false edge
            warm      <= {warm[0], 1'b1};
            primed    <= warm[1];
            det_q     <= det_s;
            btn_clr_q <= clr_s;
            rem_clr_q <= rclr_s;
            step_q    <= step_s;
        end
    end

    // pending set drops when the detector picks up, since changes are then legitimate
    wire [NPTS-1:0] next_pend = (!quiet || qual_done) ? '0 : (pend | edges);

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pend <= '0;
        end else begin
            pend <= next_pend;
        end
    end

    // ==========================================================
    // timers; qualifying time is exactly the minimum, inside the 5..10 s band
    wire [CNT_W-1:0] next_qual  = (|pend && quiet && !qual_done) ? qual_cnt + 1'b1 : '0;
    wire [CNT_W-1:0] next_stuck = (det_s && !stuck_hit) ? stuck_cnt + 1'b1 : '0;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            qual_cnt  <= '0;
            stuck_cnt <= '0;
        end else begin
            qual_cnt  <= next_qual;
            stuck_cnt <= next_stuck;
        end
    end

    // ==========================================================
    // latched state
    logic [NPTS-1:0] rec_q;
    logic [BLINK_W-1:0] blink;

    rsfm_store u_store (
        .clk      (CLK),
        .set_en   (rec_en),
        .set_bits (pend),
        .clr      (clear_cmd),
        .rd_data  (rec_q)
    );

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st    <= '0;
            blink <= '0;
        end else begin
            st.rec <= rec_q;
            blink  <= blink + 1'b1;
            if (pt_event || det_event) begin
                st.alarm <= 1'b1;
            end else if (clear_cmd) begin
                st.alarm <= 1'b0;
            end
            if (det_event) begin
                st.det_fail    <= 1'b1;
                st.code_hidden <= 1'b0;
            end else if (clear_cmd) begin
                st.det_fail    <= 1'b0;
                st.code_hidden <= 1'b0;
            end else if (st.det_fail && step_cmd) begin
                st.code_hidden <= 1'b1;
            end
        end
    end

    // ==========================================================
    // indications
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ALARM               <= 1'b0;
            MONITOR_RECORD_LAMP <= 1'b0;
            DISPLAY_CODE        <= CODE_NONE;
        end else begin
            ALARM               <= st.alarm;
            MONITOR_RECORD_LAMP <= st.det_fail ? blink[BLINK_W-1]
                                               : (|rec_q);
            DISPLAY_CODE        <= (st.det_fail && !st.code_hidden) ? CODE_FD
                                                                    : CODE_NONE;
        end
    end

    // ==========================================================
    // interrupt status and mask
    logic [ST_W-1:0] irq_st;
    logic [ST_W-1:0] irq_mask;
    wire  [ST_W-1:0] irq_set = {det_event, pt_event};
    wire             wr_go;
    wire             st_wr   = wr_go && !S_AXI_AWREADY && (S_AXI_AWADDR == REG_STATUS)
                               && S_AXI_WSTRB[0];
    wire  [ST_W-1:0] w1c     = st_wr ? S_AXI_WDATA[ST_W-1:0] : '0;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_st <= '0;
            IRQ    <= 1'b0;
        end else begin
            irq_st <= (irq_st & ~w1c) | irq_set;
            IRQ    <= |(irq_st & irq_mask);
        end
    end

    // ==========================================================
    // axi4-lite slave; address and data accepted together in one cycle
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
    wire   wr_ok = (S_AXI_AWADDR == REG_STATUS) || (S_AXI_AWADDR == REG_MASK)
                   || (S_AXI_AWADDR == REG_CONTROL);
    wire   ctl_wr = wr_go && (S_AXI_AWADDR == REG_CONTROL) && S_AXI_WSTRB[0];
    wire   rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
    logic [31:0] rd_mux;
    logic        rd_ok;

    always_comb begin
        rd_mux = '0;
        rd_ok  = 1'b1;
        case (S_AXI_ARADDR)
            REG_STATUS:  rd_mux[ST_W-1:0] = irq_st;
            REG_MASK:    rd_mux[ST_W-1:0] = irq_mask;
            REG_CONTROL: rd_mux = '0;
            REG_REC_LO:  rd_mux = st.rec[31:0];
            REG_REC_HI:  rd_mux[REC_HI_W-1:0] = st.rec[NPTS-1:32];
            REG_STATE:   rd_mux[2:0] = {st.code_hidden, st.det_fail, st.alarm};
            default:     rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= RESP_OKAY;
            S_AXI_RDATA   <= '0;
            irq_mask      <= '0;
            sw_clear      <= 1'b0;
            sw_step       <= 1'b0;
        end else begin
            S_AXI_AWREADY <= wr_go && !S_AXI_AWREADY;
            S_AXI_WREADY  <= wr_go && !S_AXI_AWREADY;
            sw_clear      <= ctl_wr && !S_AXI_AWREADY && S_AXI_WDATA[CT_CLEAR];
            sw_step       <= ctl_wr && !S_AXI_AWREADY && S_AXI_WDATA[CT_STEP];
            if (wr_go && !S_AXI_AWREADY) begin
                S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                if ((S_AXI_AWADDR == REG_MASK) && S_AXI_WSTRB[0]) begin
                    irq_mask <= S_AXI_WDATA[ST_W-1:0];
                end
            end
            // answers only follow the address handshake, as the bus demands
            if (S_AXI_AWREADY) begin
                S_AXI_BVALID <= 1'b1;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            S_AXI_ARREADY <= rd_go && !S_AXI_ARREADY;
            if (rd_go && !S_AXI_ARREADY) begin
                S_AXI_RDATA  <= rd_mux;
                S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    sequence fail_seq;
        (pt_event || det_event) ##2 ALARM;
    endsequence

    alarm_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (pt_event || det_event) |-> fail_seq)
        else $error("alarm did not close after failure");
    alarm_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (st.alarm && !clear_cmd) |=> st.alarm)
        else $error("alarm dropped without clear");
    qual_time_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        qual_done |-> ($past(qual_cnt) == QUAL_N - 1'b1) && $past((|pend) && quiet))
        else $error("qualified before delay");
    det_block_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        st.det_fail |-> !rec_en)
        else $error("recorded after detector failure");
    pend_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        det_s |=> (pend == '0))
        else $error("changes kept during disturbance");
    code_show_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (st.det_fail && !st.code_hidden) |=> (DISPLAY_CODE == CODE_FD))
        else $error("fd code missing");
    code_hide_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (st.code_hidden && st.det_fail && !clear_cmd) |=> st.code_hidden)
        else $error("fd code reappeared");
    rec_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        clear_cmd && !rec_en |=> ##1 (rec_q == '0))
        else $error("store not cleared");
    edge_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (primed && quiet && !qual_done && $changed(pts_s)) |=> (pend != '0))
        else $error("point edge missed");
endmodule

/* verif/rsfm_scheme_model.sv */
// behavioural model of the scheme logic points and the disturbance detector
// assumes the bench calls its tasks from one process, one at a time
`timescale 1ns/10ps
module rsfm_scheme_model
    import rsfm_pkg::*;
(
    // clock
    input  wire logic            clk,
    // scheme side
    output logic      [NPTS-1:0] points,
    output logic                 detector
);
    // =========================================================
    // state
    // points are held levels, never released, so no float to model
    initial begin
        points   = '0;
        detector = 1'b0;
    end

    // =========================================================
    // commands
    // one edge on one point, either direction
    task automatic flip(input int idx);
        @(posedge clk);
        points[idx] <= ~points[idx];
    endtask

    // detector picked up for n cycles, then quiet again
    task automatic hold_det(input int n);
        @(posedge clk);
        detector <= 1'b1;
        repeat (n) @(posedge clk);
        detector <= 1'b0;
    endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the failure monitor, short qualifying counts
// assumes a 25 MHz clock and the register map of the package
`timescale 1ns/10ps
module tb import rsfm_pkg::*;;
    // =========================================================
    // signals
    logic            clk, reset_n, clr_btn, rem_clr, step_btn;
    logic [NPTS-1:0] points;
    logic            detector, alarm, lamp, irq;
    logic [7:0]      code, awaddr, araddr;
    logic            awvalid, wvalid, bready, arvalid, rready;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [31:0]     wdata, rdata, rd;
    logic [3:0]      wstrb, wr_strb;
    logic [1:0]      bresp, rresp, rs;
    int              errors, compares;

    rsfm_scheme_model u_rsfm_scheme_model (.clk(clk), .points(points), .detector(detector));

    rsfm_top #(.QUAL_CYC(50), .STUCK_CYC(100)) u_rsfm_top (
        .CLK(clk), .RESET_N(reset_n), .POINTS(points), .DISTURBANCE_DETECTOR(detector),
        .CLEAR_BUTTON(clr_btn), .REMOTE_CLEAR(rem_clr), .STEP_VIEW_BUTTON(step_btn),
        .ALARM(alarm), .MONITOR_RECORD_LAMP(lamp), .DISPLAY_CODE(code), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // =========================================================
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= wr_strb;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        if (bvalid !== 1'b1) errors++;
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        if (rvalid !== 1'b1) errors++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rdr(a, rd, rs);
        chk(what, exp, rd);
        chk("read resp", RESP_OKAY, rs);
    endtask

    // pins pass a two-flop sync, so hold each press a few cycles
    task automatic press(input int k);
        @(posedge clk);
        if (k == 0) clr_btn <= 1'b1;
        else if (k == 1) rem_clr <= 1'b1;
        else step_btn <= 1'b1;
        cyc(4);
        clr_btn  <= 1'b0;
        rem_clr  <= 1'b0;
        step_btn <= 1'b0;
        cyc(4);
    endtask

    // =========================================================
    // scenarios
    task automatic t_boot;
        wr(REG_CONTROL, 32'h1, rs); // stored set is unknown until first clear
        chk("clear resp", RESP_OKAY, rs);
        cyc(3);
        chk("alarm idle", 0, alarm);
        rchk("rec lo", REG_REC_LO, 0);
        rchk("rec hi", REG_REC_HI, 0);
        rchk("state", REG_STATE, 0);
        rchk("control", REG_CONTROL, 0);
        rdr(8'h20, rd, rs);
        chk("unmapped rd resp", RESP_SLVERR, rs);
        chk("unmapped rd data", 0, rd);
        wr(8'h20, 32'h1, rs);
        chk("unmapped wr resp", RESP_SLVERR, rs);
        wr(REG_MASK, 32'h3, rs);
        rchk("mask", REG_MASK, 32'h3);
        // byte lane 0 off: the mask must keep its value
        wr_strb = 4'h0;
        wr(REG_MASK, 32'h0, rs);
        wr_strb = 4'hf;
        rchk("mask strobe off", REG_MASK, 32'h3);
        $display("test boot done");
    endtask

    task automatic t_rise;
        u_rsfm_scheme_model.flip(0);
        cyc(45);
        chk("alarm early", 0, alarm);
        cyc(25);
        chk("alarm", 1, alarm);
        rchk("rec lo", REG_REC_LO, 32'h1);
        chk("lamp on", 1, lamp);
        rchk("status", REG_STATUS, 32'h1);
        chk("irq", 1, irq);
        $display("test rise done");
    endtask

    task automatic t_accum;
        u_rsfm_scheme_model.flip(0);
        u_rsfm_scheme_model.flip(39);
        cyc(80);
        rchk("rec lo", REG_REC_LO, 32'h1);
        rchk("rec hi", REG_REC_HI, 32'h80);
        wr(REG_STATUS, 32'h1, rs);
        cyc(2);
        rchk("status w1c", REG_STATUS, 0);
        chk("irq cleared", 0, irq);
        chk("alarm latched", 1, alarm);
        $display("test accumulate done");
    endtask

    task automatic t_quiet;
        press(0);
        chk("alarm after clear", 0, alarm);
        chk("lamp off", 0, lamp);
        rchk("rec lo cleared", REG_REC_LO, 0);
        rchk("rec hi cleared", REG_REC_HI, 0);
        u_rsfm_scheme_model.flip(5);
        u_rsfm_scheme_model.hold_det(60);
        cyc(80);
        chk("alarm disturbed", 0, alarm);
        rchk("rec lo disturbed", REG_REC_LO, 0);
        $display("test quiet done");
    endtask

    // stored set rides through a reset like a supply loss; point 39 stays high
    task automatic t_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        cyc(2);
        reset_n <= 1'b1;
        chk("alarm in reset", 0, alarm);
        rchk("rec lo kept", REG_REC_LO, 32'h1);
        rchk("rec hi kept", REG_REC_HI, 32'h80);
        cyc(60);
        chk("no edge from reset", 0, alarm);
        $display("test reset done");
    endtask

    task automatic t_stuck;
        wr(REG_MASK, 0, rs);
        u_rsfm_scheme_model.hold_det(120);
        cyc(2);
        chk("alarm stuck", 1, alarm);
        chk("code fd", CODE_FD, code);
        rchk("state stuck", REG_STATE, 32'h3);
        rchk("status stuck", REG_STATUS, 32'h2);
        chk("irq masked", 0, irq);
        wr(REG_MASK, 32'h2, rs);
        cyc(2);
        chk("irq unmasked", 1, irq);
        u_rsfm_scheme_model.flip(7);
        cyc(80);
        rchk("no record", REG_REC_LO, 0);
        press(2);
        chk("code hidden", CODE_NONE, code);
        rchk("state hidden", REG_STATE, 32'h7);
        press(1);
        chk("alarm remote clear", 0, alarm);
        rchk("state cleared", REG_STATE, 0);
        $display("test stuck done");
    endtask

    // =========================================================
    // run control
    task automatic close_out;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 5000);
        errors++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        {reset_n, clr_btn, rem_clr, step_btn} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata  = '0;
        wstrb  = '0;
        wr_strb = 4'hf;
        errors = 0;
        compares = 0;
        cyc(2);
        reset_n <= 1'b1;
        t_boot();
        t_rise();
        t_accum();
        t_reset();
        t_quiet();
        t_stuck();
        close_out();
    end
endmodule
